// ### core/rss_top.sv
// Reset source sequencer: merges reset sources, stretches reset, records the cause
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module rss_top #(
    parameter int unsigned DLY_W = rss_pkg::DLY_W,
    parameter int unsigned TOUT_MID_CYC = rss_pkg::TOUT_MID_CYC,
    parameter int unsigned TOUT_LONG_CYC = rss_pkg::TOUT_LONG_CYC,
    parameter int unsigned START_XTAL_CYC = rss_pkg::START_XTAL_CK,
    parameter int unsigned PIN_MIN_LOW_CYC = rss_pkg::PIN_MIN_LOW_CYC
) (
    // Clock and logic reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Reset sources
    input wire logic poweron_below_i,
    input wire logic brownout_below_i,
    input wire logic ext_reset_n_i,
    input wire logic watchdog_timeout_i,
    input wire logic watchdog_enabled_i,
    // Configuration
    input wire rss_pkg::rss_fuse_s fuses_i,
    input wire logic pin_reset_en_i,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reset outputs and interrupt
    output logic sys_reset_o,
    output logic fetch_start_o,
    output logic irq_o
);
    // Synchronised sources, detector enables and the raw source merge
    logic por_s;
    logic bod_raw_s;
    logic pin_n_s;
    logic bod_en;
    logic pin_en;
    logic async_src;

    // Source activity
    logic por_act;
    logic bod_act;
    logic pin_act_r;
    logic [$clog2(PIN_MIN_LOW_CYC+1)-1:0] pin_low_cnt_r;
    logic wd_pulse_r;
    logic hold;
    rss_pkg::rss_cause_s act_d_r;
    rss_pkg::rss_cause_s act_now;

    // Sequencer
    rss_pkg::rss_state_e state_r;
    rss_pkg::rss_state_e state_nxt;
    logic expired;
    logic [DLY_W-1:0] delay_sel;
    logic sys_reset_r;
    logic fetch_r;

    // Registers
    rss_pkg::rss_cause_s cause_r;
    rss_pkg::rss_cause_s cause_nxt;
    logic [3:0] evt_r;
    logic [3:0] evt_nxt;
    logic [3:0] evt_en_r;
    logic [3:0] evt_raw;
    logic irq_r;

    // Bus
    logic setup;
    logic wr_fire;
    logic [31:0] rd_data;
    logic rd_err;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // Detector enables from fuses and configuration
    assign bod_en = (fuses_i.brownout_level_fuses != rss_pkg::BOD_DISABLED);
    assign pin_en = pin_reset_en_i;

    // Raw analog and pin sources; these set the reset flop without a clock
    assign async_src = poweron_below_i
                     | (bod_en & brownout_below_i)
                     | (pin_en & ~ext_reset_n_i);

    // The power-on, brown-out and pin sources cross into the clock domain through the filter
    rss_sync3 #(
        .WIDTH(3),
        .RST_VAL(3'h5)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .async_i({poweron_below_i, brownout_below_i, ext_reset_n_i}),
        .sync_o({por_s, bod_raw_s, pin_n_s})
    );

    assign por_act = por_s;
    assign bod_act = bod_en & bod_raw_s;

    // Pin must stay low for the minimum width; a shorter low holds reset only until the clock after it ends, with no stretch or cause
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            pin_low_cnt_r <= '0;
            pin_act_r <= 1'b0;
        end
        else if (!pin_en || pin_n_s)
        begin
            pin_low_cnt_r <= '0;
            pin_act_r <= 1'b0;
        end
        else if (pin_low_cnt_r != ($bits(pin_low_cnt_r))'(PIN_MIN_LOW_CYC))
        begin
            pin_low_cnt_r <= pin_low_cnt_r + ($bits(pin_low_cnt_r))'(1);
            pin_act_r <= 1'b0;
        end
        else
        begin
            pin_act_r <= 1'b1;
        end
    end

    // Watchdog expiry becomes a single-cycle internal reset pulse
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            wd_pulse_r <= 1'b0;
        end
        else
        begin
            wd_pulse_r <= watchdog_timeout_i & watchdog_enabled_i & ~wd_pulse_r;
        end
    end

    // The four merged causes
    assign act_now = '{watchdog_cause_flag: wd_pulse_r, brownout_cause_flag: bod_act,
                       pin_cause_flag: pin_act_r, poweron_cause_flag: por_act};
    assign hold = |act_now;

    // Delay period from start-up time and clock select fuses
    always_comb
    begin
        logic [DLY_W-1:0] tout;
        logic [DLY_W-1:0] start;
        tout = DLY_W'(TOUT_LONG_CYC);
        start = DLY_W'(rss_pkg::START_RC_CK);
        if (fuses_i.startup_time_fuses == rss_pkg::SUT_SHORT)
        begin
            tout = DLY_W'(rss_pkg::TOUT_SHORT_CK);
        end
        else if (fuses_i.startup_time_fuses == rss_pkg::SUT_MID)
        begin
            tout = DLY_W'(TOUT_MID_CYC);
        end
        if (fuses_i.clock_select_fuses[rss_pkg::CLOCK_SELECT_FUSES_XTAL_BIT])
        begin
            start = DLY_W'(START_XTAL_CYC);
        end
        delay_sel = tout + start;
    end

    // Counter reloads in every cycle a source is active, so it starts on the last drop
    rss_delay_counter #(
        .CNT_W(DLY_W)
    ) u_delay (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .load_i(hold),
        .value_i(delay_sel),
        .expired_o(expired)
    );

    // Release sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            rss_pkg::RSS_HOLD:
            begin
                if (!hold)
                begin
                    state_nxt = rss_pkg::RSS_STRETCH;
                end
            end
            rss_pkg::RSS_STRETCH:
            begin
                if (hold)
                begin
                    state_nxt = rss_pkg::RSS_HOLD;
                end
                else if (expired)
                begin
                    state_nxt = rss_pkg::RSS_RUN;
                end
            end
            rss_pkg::RSS_RUN:
            begin
                if (hold)
                begin
                    state_nxt = rss_pkg::RSS_HOLD;
                end
            end
            default:
            begin
                state_nxt = rss_pkg::RSS_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            state_r <= rss_pkg::RSS_HOLD;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Reset output: set at once by analog or pin sources, released only by the sequencer
    always_ff @(posedge clk_sys_i or posedge async_src)
    begin
        if (async_src)
        begin
            sys_reset_r <= 1'b1;
        end
        else if (!rstn_i)
        begin
            sys_reset_r <= 1'b1;
        end
        else
        begin
            sys_reset_r <= (state_nxt != rss_pkg::RSS_RUN);
        end
    end

    // Fetch start pulse on the release edge
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            fetch_r <= 1'b0;
        end
        else
        begin
            fetch_r <= (state_r != rss_pkg::RSS_RUN) && (state_nxt == rss_pkg::RSS_RUN);
        end
    end

    // Bus handshake: read data captured in setup, answered in the first access cycle
    assign setup = psel && !penable;
    assign wr_fire = psel && penable && pwrite && pready_r;

    // Cause flags: software zero clears, a new cause wins, power-on clears the rest
    always_comb
    begin
        cause_nxt = cause_r;
        if (wr_fire && (paddr == rss_pkg::OFS_CAUSE))
        begin
            cause_nxt = cause_r & rss_pkg::rss_cause_s'(pwdata[3:0]);
        end
        cause_nxt = cause_nxt | act_now;
        if (por_act)
        begin
            cause_nxt.watchdog_cause_flag = 1'b0;
            cause_nxt.brownout_cause_flag = 1'b0;
            cause_nxt.pin_cause_flag = 1'b0;
        end
    end

    // Logic reset only comes with power-up, so the power-on flag reads set after it
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            cause_r <= rss_pkg::rss_cause_s'(rss_pkg::CAUSE_RST);
        end
        else
        begin
            cause_r <= cause_nxt;
        end
    end

    // Event edges for the interrupt status
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            act_d_r <= '0;
        end
        else
        begin
            act_d_r <= act_now;
        end
    end

    assign evt_raw = act_now & ~act_d_r;

    // Event status: write one to the clear register; a new event wins over the clear
    always_comb
    begin
        evt_nxt = evt_r;
        if (wr_fire && (paddr == rss_pkg::OFS_EVT_CLEAR))
        begin
            evt_nxt = evt_r & ~pwdata[3:0];
        end
        evt_nxt = evt_nxt | evt_raw;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            evt_r <= rss_pkg::EVT_STATUS_RST;
            evt_en_r <= rss_pkg::EVT_ENABLE_RST;
        end
        else
        begin
            evt_r <= evt_nxt;
            if (wr_fire && (paddr == rss_pkg::OFS_EVT_ENABLE))
            begin
                evt_en_r <= pwdata[3:0];
            end
        end
    end

    // Interrupt level follows the next-state values so it never lags the status
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            irq_r <= 1'b0;
        end
        else if (wr_fire && (paddr == rss_pkg::OFS_EVT_ENABLE))
        begin
            irq_r <= |(evt_nxt & pwdata[3:0]);
        end
        else
        begin
            irq_r <= |(evt_nxt & evt_en_r);
        end
    end

    // Read mux; the clear register reads zero, unmapped addresses answer with an error
    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            rss_pkg::OFS_CAUSE:
            begin
                rd_data = {28'h000_0000, cause_r};
            end
            rss_pkg::OFS_EVT_STATUS:
            begin
                rd_data = {28'h000_0000, evt_r};
            end
            rss_pkg::OFS_EVT_ENABLE:
            begin
                rd_data = {28'h000_0000, evt_en_r};
            end
            rss_pkg::OFS_EVT_CLEAR:
            begin
                rd_data = 32'h0000_0000;
            end
            rss_pkg::OFS_STATE:
            begin
                rd_data[rss_pkg::ST_RESET_BIT] = sys_reset_r;
                rd_data[rss_pkg::ST_STRETCH_BIT] = (state_r == rss_pkg::RSS_STRETCH);
                rd_data[rss_pkg::ST_BOD_EN_BIT] = bod_en;
                rd_data[rss_pkg::ST_PIN_EN_BIT] = pin_en;
            end
            default:
            begin
                rd_err = 1'b1;
            end
        endcase
    end

    // One wait-free access cycle: pready rises in the cycle after setup
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= setup;
            if (setup)
            begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr_r <= rd_err;
            end
            else
            begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // Outputs
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sys_reset_o = sys_reset_r;
    assign fetch_start_o = fetch_r;
    assign irq_o = irq_r;
endmodule : rss_top

// ### core/rss_pkg.sv
// Shared constants, register map and carrier types of the reset source sequencer
package rss_pkg;
    // System clock
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;

    // APB register map, byte addresses
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_CAUSE = 12'h000;
    localparam logic [11:0] OFS_EVT_STATUS = 12'h004;
    localparam logic [11:0] OFS_EVT_ENABLE = 12'h008;
    localparam logic [11:0] OFS_EVT_CLEAR = 12'h00c;
    localparam logic [11:0] OFS_STATE = 12'h010;

    // Cause and event field layout (same layout in all four registers)
    localparam int unsigned CAUSE_W = 4;
    localparam int unsigned POWERON_BIT = 0;
    localparam int unsigned PIN_BIT = 1;
    localparam int unsigned BROWNOUT_BIT = 2;
    localparam int unsigned WATCHDOG_BIT = 3;
    localparam logic [3:0] CAUSE_RST = 4'h1;
    localparam logic [3:0] EVT_STATUS_RST = 4'h0;
    localparam logic [3:0] EVT_ENABLE_RST = 4'h0;

    // State register fields
    localparam int unsigned ST_RESET_BIT = 0;
    localparam int unsigned ST_STRETCH_BIT = 1;
    localparam int unsigned ST_BOD_EN_BIT = 2;
    localparam int unsigned ST_PIN_EN_BIT = 3;

    // Fuse codes
    localparam logic [2:0] BOD_DISABLED = 3'h7;
    localparam logic [1:0] SUT_SHORT = 2'h0;
    localparam logic [1:0] SUT_MID = 2'h1;
    localparam int unsigned CLOCK_SELECT_FUSES_XTAL_BIT = 3;

    // Timing: pin low filter (least time, rounds up)
    localparam int unsigned PIN_MIN_LOW_NS = 2500;
    localparam int unsigned PIN_MIN_LOW_CYC = (PIN_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Timing: delay counter time-out choices
    localparam int unsigned TOUT_SHORT_CK = 14;
    localparam int unsigned TOUT_MID_US = 4000;
    localparam int unsigned TOUT_LONG_US = 64000;
    localparam int unsigned TOUT_MID_CYC = TOUT_MID_US * CLK_PER_US;
    localparam int unsigned TOUT_LONG_CYC = TOUT_LONG_US * CLK_PER_US;
    localparam int unsigned START_RC_CK = 6;
    localparam int unsigned START_XTAL_CK = 16384;
    localparam int unsigned DLY_W = 24;

    // Fuse group as seen by the sequencer
    typedef struct packed {
        logic [1:0] startup_time_fuses;
        logic [3:0] clock_select_fuses;
        logic [2:0] brownout_level_fuses;
    } rss_fuse_s;

    // Reset cause flags, bit order as in the status register
    typedef struct packed {
        logic watchdog_cause_flag;
        logic brownout_cause_flag;
        logic pin_cause_flag;
        logic poweron_cause_flag;
    } rss_cause_s;

    // Release sequencer states
    typedef enum logic [1:0] {
        RSS_HOLD,
        RSS_STRETCH,
        RSS_RUN
    } rss_state_e;
endpackage : rss_pkg

// ### core/rss_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module rss_sync3 #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Asynchronous inputs and filtered result
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;

    // Stage one feeds stage two only; a change counts once stages two and three agree
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            out_r <= RST_VAL;
        end
        else
        begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & out_r);
        end
    end

    assign sync_o = out_r;
endmodule : rss_sync3

// ### core/rss_delay_counter.sv
// Reloadable down counter that stretches the internal reset
`timescale 1ns/1ps
module rss_delay_counter #(
    parameter int unsigned CNT_W = 24
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Reload while a source is active, count down otherwise
    input wire logic load_i,
    input wire logic [CNT_W-1:0] value_i,
    output logic expired_o
);
    logic [CNT_W-1:0] cnt_r;
    logic expired_r;

    // A load always restarts the full period, so a new source mid-count is never shortened
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            cnt_r <= '0;
            expired_r <= 1'b0;
        end
        else if (load_i)
        begin
            cnt_r <= value_i;
            expired_r <= 1'b0;
        end
        else if (cnt_r != '0)
        begin
            cnt_r <= cnt_r - CNT_W'(1);
            expired_r <= 1'b0;
        end
        else
        begin
            expired_r <= 1'b1;
        end
    end

    assign expired_o = expired_r;
endmodule : rss_delay_counter

// ### verification/rss_src_model.sv
// Behavioural model of the supply detectors, reset pin and watchdog
`timescale 1ns/1ps
module rss_src_model (
    // Clock
    input wire logic clk_sys_i,
    // Commands from the bench
    input wire logic vdd_low_i,
    input wire logic bod_low_i,
    input wire logic pin_low_i,
    input wire logic wd_fire_i,
    input wire logic wd_arm_i,
    // Source levels seen by the sequencer
    output logic poweron_below_o,
    output logic brownout_below_o,
    output logic ext_reset_n_o,
    output logic watchdog_timeout_o,
    output logic watchdog_enabled_o
);
    logic fire_q = 1'b0;

    // Detector levels follow the supply at once, as analog comparators do
    assign poweron_below_o = vdd_low_i;
    assign brownout_below_o = bod_low_i;
    // The pin has a pull-up, so a released pin reads high
    assign ext_reset_n_o = ~pin_low_i;
    assign watchdog_enabled_o = wd_arm_i;

    // Edge detect keeps a long fire request from repeating the one-clock pulse
    always @(posedge clk_sys_i)
    begin
        fire_q <= wd_fire_i;
    end
    assign watchdog_timeout_o = wd_fire_i & ~fire_q;
endmodule : rss_src_model

// ### verification/rss_top_sva.sv
// Concurrent checks on the ports of the reset source sequencer
`timescale 1ns/1ps
module rss_top_chk (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Sources and configuration
    input wire logic poweron_below_i,
    input wire logic brownout_below_i,
    input wire logic ext_reset_n_i,
    input wire logic watchdog_timeout_i,
    input wire logic watchdog_enabled_i,
    input wire rss_pkg::rss_fuse_s fuses_i,
    input wire logic pin_reset_en_i,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Outputs
    input wire logic sys_reset_o,
    input wire logic fetch_start_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    chk_por_force: assert property (poweron_below_i |-> sys_reset_o)
        else $error("power-on source did not hold reset");
    chk_bod_force: assert property (brownout_below_i
        && fuses_i.brownout_level_fuses != rss_pkg::BOD_DISABLED |-> sys_reset_o)
        else $error("brown-out source did not hold reset");
    chk_pin_reset: assert property ((!ext_reset_n_i && pin_reset_en_i) [*8] |-> sys_reset_o)
        else $error("long pin low did not reset");
    chk_wd_pulse: assert property (watchdog_timeout_i && watchdog_enabled_i
        |-> ##2 sys_reset_o)
        else $error("watchdog time-out did not reset");
    chk_wd_masked: assert property (watchdog_timeout_i && !watchdog_enabled_i
        && !sys_reset_o && !poweron_below_i && !brownout_below_i && ext_reset_n_i
        |=> !sys_reset_o)
        else $error("disarmed watchdog caused reset");
    // Shortest delay is 20 clocks (14 plus 6 of start-up), so a release 14 clocks after a power-on or pin source is too early
    chk_stretch_min: assert property ($fell(sys_reset_o)
        |-> !$past(poweron_below_i, 14) && $past(ext_reset_n_i, 14))
        else $error("reset released without stretch");
    chk_fetch_pulse: assert property ($fell(sys_reset_o) |-> fetch_start_o ##1 !fetch_start_o)
        else $error("no single fetch pulse at release");
    chk_reserved_zero: assert property (pready && !pwrite |-> prdata[31:4] == 28'h0)
        else $error("reserved read bits not zero");
    chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single cycle after setup");
    chk_bad_addr: assert property (psel && !penable && paddr > rss_pkg::OFS_STATE |=> pslverr)
        else $error("unmapped address not refused");
endmodule : rss_top_chk

bind rss_top rss_top_chk u_chk (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .poweron_below_i(poweron_below_i),
    .brownout_below_i(brownout_below_i), .ext_reset_n_i(ext_reset_n_i),
    .watchdog_timeout_i(watchdog_timeout_i), .watchdog_enabled_i(watchdog_enabled_i),
    .fuses_i(fuses_i), .pin_reset_en_i(pin_reset_en_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_reset_o(sys_reset_o), .fetch_start_o(fetch_start_o), .irq_o(irq_o)
);

// ### verification/rss_top_tb.sv
// Self-checking bench of the reset source sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module rss_top_tb;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic vdd_low = 1'b0, bod_low = 1'b0, pin_low = 1'b0, wd_fire = 1'b0, wd_arm = 1'b0;
    logic pin_reset_en_i = 1'b1;
    rss_pkg::rss_fuse_s fuses_i = '{2'h0, 4'h0, 3'h6};
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sys_reset_o, fetch_start_o, irq_o, err;
    logic po_b, bo_b, pin_n, wd_to, wd_en;
    int error_cnt = 0, n_compared = 0, cyc;
    // Short time-out of 14 clocks plus 6 clocks of start-up
    localparam int DLY = 20;

    always #25 clk_sys_i = ~clk_sys_i;

    rss_src_model u_src (.clk_sys_i(clk_sys_i), .vdd_low_i(vdd_low), .bod_low_i(bod_low),
        .pin_low_i(pin_low), .wd_fire_i(wd_fire), .wd_arm_i(wd_arm), .poweron_below_o(po_b),
        .brownout_below_o(bo_b), .ext_reset_n_o(pin_n), .watchdog_timeout_o(wd_to),
        .watchdog_enabled_o(wd_en));

    // Shortened counts keep the run brief; the short time-out is used except in t_delay_sel
    rss_top #(.TOUT_MID_CYC(20), .TOUT_LONG_CYC(40), .START_XTAL_CYC(8), .PIN_MIN_LOW_CYC(4)) dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .poweron_below_i(po_b), .brownout_below_i(bo_b),
        .ext_reset_n_i(pin_n), .watchdog_timeout_i(wd_to), .watchdog_enabled_i(wd_en),
        .fuses_i(fuses_i), .pin_reset_en_i(pin_reset_en_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sys_reset_o(sys_reset_o), .fetch_start_o(fetch_start_o),
        .irq_o(irq_o));

    task final_report();
        if (error_cnt == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    // One APB transfer; request held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            error_cnt++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Bounded wait for the reset output to reach a level, counting clocks
    task wait_rst(input logic lvl);
        cyc = 0;
        while (sys_reset_o !== lvl && cyc < 300)
        begin
            @(posedge clk_sys_i);
            #1;
            cyc++;
        end
        if (cyc >= 300)
        begin
            error_cnt++;
            final_report();
        end
    endtask : wait_rst

    task pulse_wd();
        @(posedge clk_sys_i);
        wd_fire <= 1'b1;
        @(posedge clk_sys_i);
        wd_fire <= 1'b0;
    endtask : pulse_wd

    task t_power_up();
        wait_rst(1'b0);
        `CHK(cyc >= DLY, 1'b1)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b1, 12'h000, 32'hf);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 12'h020, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b0, 12'h010, 32'h0);
        `CHK(rd, 32'hc)
        // The power-on cause left an event behind; clear it before enabling the interrupt
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b1, 12'h00c, 32'hf);
        apb(1'b1, 12'h008, 32'hf);
    endtask : t_power_up

    task t_watchdog();
        pulse_wd();
        // Arm at the edge that ends the pulse, so that pulse is still seen unarmed
        wd_arm <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        `CHK(sys_reset_o, 1'b0)
        pulse_wd();
        wait_rst(1'b1);
        `CHK(cyc <= 4, 1'b1)
        wait_rst(1'b0);
        `CHK(cyc >= DLY && cyc <= DLY + 6, 1'b1)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h8)
        `CHK(irq_o, 1'b1)
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h8)
        apb(1'b1, 12'h00c, 32'h8);
        apb(1'b1, 12'h000, 32'h0);
        #1;
        `CHK(irq_o, 1'b0)
    endtask : t_watchdog

    task t_brownout();
        @(posedge clk_sys_i);
        fuses_i.brownout_level_fuses <= 3'h7;
        bod_low <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        #1;
        `CHK(sys_reset_o, 1'b0)
        @(posedge clk_sys_i);
        bod_low <= 1'b0;
        // Fuses are static: enable only once the filtered detector has gone quiet
        repeat (4) @(posedge clk_sys_i);
        fuses_i.brownout_level_fuses <= 3'h6;
        apb(1'b1, 12'h008, 32'h0);
        @(posedge clk_sys_i);
        bod_low <= 1'b1;
        #1;
        `CHK(sys_reset_o, 1'b1)
        repeat (5) @(posedge clk_sys_i);
        bod_low <= 1'b0;
        wait_rst(1'b0);
        `CHK(cyc >= DLY && cyc <= DLY + 6, 1'b1)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h4)
        `CHK(irq_o, 1'b0)
        apb(1'b1, 12'h008, 32'hf);
        repeat (2) @(posedge clk_sys_i);
        #1;
        `CHK(irq_o, 1'b1)
        apb(1'b1, 12'h00c, 32'hf);
        apb(1'b1, 12'h000, 32'h0);
    endtask : t_brownout

    task t_pin();
        @(posedge clk_sys_i);
        pin_reset_en_i <= 1'b0;
        pin_low <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
        #1;
        `CHK(sys_reset_o, 1'b0)
        @(posedge clk_sys_i);
        pin_low <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        pin_reset_en_i <= 1'b1;
        @(posedge clk_sys_i);
        pin_low <= 1'b1;
        repeat (12) @(posedge clk_sys_i);
        #1;
        `CHK(sys_reset_o, 1'b1)
        @(posedge clk_sys_i);
        pin_low <= 1'b0;
        wait_rst(1'b0);
        // The pin width filter adds one register stage over the other sources
        `CHK(cyc >= DLY && cyc <= DLY + 7, 1'b1)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h2)
    endtask : t_pin

    // Pin and watchdog flags stand when power fails; power-on must replace them
    task t_poweron();
        pulse_wd();
        wait_rst(1'b1);
        wait_rst(1'b0);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'ha)
        @(posedge clk_sys_i);
        vdd_low <= 1'b1;
        #1;
        `CHK(sys_reset_o, 1'b1)
        repeat (4) @(posedge clk_sys_i);
        vdd_low <= 1'b0;
        wait_rst(1'b0);
        `CHK(cyc >= DLY && cyc <= DLY + 6, 1'b1)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h1)
    endtask : t_poweron

    // Mid time-out (20) plus crystal start-up (8), as shortened in this bench
    task t_delay_sel();
        fuses_i <= '{2'h1, 4'h8, 3'h6};
        pulse_wd();
        wait_rst(1'b1);
        wait_rst(1'b0);
        `CHK(cyc >= 28 && cyc <= 34, 1'b1)
    endtask : t_delay_sel

    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_power_up();
        t_watchdog();
        t_brownout();
        t_pin();
        t_poweron();
        t_delay_sel();
        final_report();
    end
endmodule : rss_top_tb
